//--- src/cpd_pkg.sv
// constants, field layout and decode helpers for the configuration protection decoder
package cpd_pkg;

  // ==========================================================================
  // register offsets (word addresses on the register port)
  localparam logic [15:0] CFG4_ADDR   = 16'h800a;
  localparam logic [15:0] CFG5_ADDR   = 16'h800b;
  localparam logic [15:0] STAT_ADDR   = 16'h800c;
  localparam logic [15:0] WDTC_ADDR   = 16'h800d;

  // ==========================================================================
  // field positions in memory_write_protect_config
  localparam int LVP_BIT      = 13;
  localparam int SAF_WP_BIT   = 11;
  localparam int EE_WP_BIT    = 10;
  localparam int CFG_WP_BIT   = 9;
  localparam int BB_WP_BIT    = 8;
  localparam int APP_WP_BIT   = 7;
  localparam int SAF_EN_BIT   = 4;
  localparam int BB_EN_BIT    = 3;
  localparam int BB_SZ_LSB    = 0;
  // field position in code_protect_config
  localparam int CP_BIT       = 0;
  // software period field in watchdog_control_zero
  localparam int WDT_SW_LSB   = 0;

  // ==========================================================================
  // masks and values after reset / bulk erase
  localparam logic [13:0] CFG_ERASED  = 14'h3fff;
  localparam logic [13:0] CFG4_IMPL   = 14'h2f9f;
  localparam logic [13:0] CFG4_STICKY = 14'h0f98;
  localparam logic [13:0] CFG5_IMPL   = 14'h0001;
  localparam logic [13:0] RD_ZERO     = 14'h0000;

  // ==========================================================================
  // watchdog period coding
  localparam logic [4:0] WDT_SW_CTRL  = 5'h1f;
  localparam logic [4:0] WDT_SW_RST   = 5'h0b;
  localparam logic [4:0] WDT_MAX_CODE = 5'h12;
  localparam logic [4:0] WDT_MIN_EXP  = 5'h05;

  // ==========================================================================
  // program memory geometry in words
  localparam logic [15:0] PM_WORDS    = 16'h2000;
  localparam logic [15:0] SAF_WORDS   = 16'h0080;
  localparam logic [15:0] BB_W_SMALL  = 16'h0200;
  localparam logic [15:0] BB_W_MID    = 16'h0400;
  localparam logic [15:0] BB_W_LARGE  = 16'h0800;
  localparam logic [2:0]  BB_SZ_SMALL = 3'h7;
  localparam logic [2:0]  BB_SZ_MID   = 3'h6;

  // divider exponent for a selector code; out-of-table codes give the minimum
  function automatic logic [4:0] wdt_exp(input logic [4:0] code);
    wdt_exp = (code > WDT_MAX_CODE) ? WDT_MIN_EXP : 5'(code + WDT_MIN_EXP);
  endfunction : wdt_exp

  // boot block length in words, zero when disabled, clamped to half of memory
  function automatic logic [15:0] bb_words(input logic en_n, input logic [2:0] sz);
    logic [15:0] w;
    w = (sz == BB_SZ_SMALL) ? BB_W_SMALL : (sz == BB_SZ_MID) ? BB_W_MID : BB_W_LARGE;
    if (w > (PM_WORDS >> 1))
      w = PM_WORDS >> 1;
    bb_words = en_n ? 16'h0000 : w;
  endfunction : bb_words

endpackage : cpd_pkg

//--- src/cpd_cfg_if.sv
// active configuration snapshot and its decoded results, shared by the decoders
`timescale 1ns/1ps
`default_nettype none
interface cpd_cfg_if;
  logic        low_voltage_prog_enable;
  logic        saf_wp_n;
  logic        ee_wp_n;
  logic        cfg_wp_n;
  logic        bb_wp_n;
  logic        app_wp_n;
  logic        saf_en_n;
  logic        bb_en_n;
  logic [2:0]  bb_size;
  logic [4:0]  wdt_sel;
  logic [4:0]  wdt_sw;
  logic [4:0]  wdt_eff;
  logic [4:0]  wdt_exp;
  logic        wdt_sw_ok;
  logic [15:0] bb_len;

  modport top   (output low_voltage_prog_enable, saf_wp_n, ee_wp_n, cfg_wp_n, bb_wp_n, app_wp_n, saf_en_n,
                 bb_en_n, bb_size, wdt_sel, wdt_sw,
                 input wdt_eff, wdt_exp, wdt_sw_ok, bb_len);
  modport wdt   (input wdt_sel, wdt_sw, output wdt_eff, wdt_exp, wdt_sw_ok);
  modport guard (input saf_wp_n, bb_wp_n, app_wp_n, saf_en_n, bb_en_n, bb_size,
                 output bb_len);
endinterface : cpd_cfg_if
`default_nettype wire

//--- src/cpd_wdt_period.sv
// watchdog period selector decode
`timescale 1ns/1ps
`default_nettype none
module cpd_wdt_period (
  cpd_cfg_if.wdt cfg
);

  // ==========================================================================
  // effective code and divider exponent
  always_comb
  begin
    cfg.wdt_sw_ok = (cfg.wdt_sel == cpd_pkg::WDT_SW_CTRL);
    cfg.wdt_eff   = cfg.wdt_sw_ok ? cfg.wdt_sw : cfg.wdt_sel;
    cfg.wdt_exp   = cpd_pkg::wdt_exp(cfg.wdt_eff);
  end

endmodule : cpd_wdt_period
`default_nettype wire

//--- src/cpd_region_guard.sv
// program memory region decode and write permission
`timescale 1ns/1ps
`default_nettype none
module cpd_region_guard (
  cpd_cfg_if.guard   cfg,
  input  wire logic [15:0] addr,
  output logic       in_boot,
  output logic       in_saf,
  output logic       addr_ok,
  output logic       allow
);

  // ==========================================================================
  // region membership; the storage area sits at the top of program memory
  always_comb
  begin
    cfg.bb_len = cpd_pkg::bb_words(cfg.bb_en_n, cfg.bb_size);
    addr_ok    = (addr < cpd_pkg::PM_WORDS);
    in_boot    = addr_ok && (addr < cfg.bb_len);
    in_saf     = addr_ok && !cfg.saf_en_n
                 && (addr >= 16'(cpd_pkg::PM_WORDS - cpd_pkg::SAF_WORDS));
    if (!addr_ok)
      allow = 1'b0;
    else if (in_boot)
      allow = cfg.bb_wp_n;
    else if (in_saf)
      allow = cfg.saf_wp_n;
    else
      allow = cfg.app_wp_n;
  end

endmodule : cpd_region_guard
`default_nettype wire

//--- src/cpd_top.sv
// configuration protection decoder: config image, snapshot, permissions, register port
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cpd_top (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [13:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [13:0] reg_rdata,
  // nonvolatile configuration image
  input  wire logic [13:0] nv_cfg4,
  input  wire logic [13:0] nv_cfg5,
  input  wire logic        bulk_erase,
  input  wire logic        lvp_session,
  input  wire logic        reset_pin_enable,
  input  wire logic        external_reset_pin_n,
  // memory write requests
  input  wire logic        prog_wr_req,
  input  wire logic [15:0] prog_wr_addr,
  input  wire logic        eeprom_wr_req,
  // decoded outputs
  output logic             cfg_valid,
  output logic             prog_wr_grant,
  output logic             eeprom_wr_grant,
  output logic             storage_area_flash_on,
  output logic             code_protect_on,
  output logic             pin_reset,
  output logic             hv_prog_required,
  output logic      [4:0]  watchdog_period_select,
  output logic      [4:0]  wdt_ratio_exp,
  output logic      [15:0] boot_block_words,
  output logic      [15:0] boot_block_last
);

  // ==========================================================================
  // reset release synchroniser
  logic rst_a_q;
  logic rst_b_q;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_a_q <= 1'b0;
      rst_b_q <= 1'b0;
    end
    else
    begin
      rst_a_q <= 1'b1;
      rst_b_q <= rst_a_q;
    end
  end

  wire logic rst_n = rst_b_q;

  // ==========================================================================
  // reset pin synchroniser: a change counts once stages two and three agree
  logic [2:0] pin_sync_q;
  logic       pin_lvl_q;
  logic       pin_lvl_d;

  always_comb
  begin
    pin_lvl_d = (pin_sync_q[1] == pin_sync_q[2]) ? pin_sync_q[2] : pin_lvl_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_sync_q <= 3'h7;
      pin_lvl_q  <= 1'b1;
    end
    else if (clk_en)
    begin
      pin_sync_q <= {pin_sync_q[1:0], external_reset_pin_n};
      pin_lvl_q  <= pin_lvl_d;
    end
  end

  // ==========================================================================
  // configuration image, snapshot and software period
  logic [13:0] img4_q;
  logic [13:0] img4_d;
  logic [13:0] img5_q;
  logic [13:0] img5_d;
  logic [13:0] act4_q;
  logic [13:0] act4_d;
  logic [13:0] act5_q;
  logic [13:0] act5_d;
  logic [4:0]  wsw_q;
  logic [4:0]  wsw_d;
  logic        loaded_q;
  logic        loaded_d;
  logic        pin_en_q;
  logic        pin_en_d;
  logic        wr4;
  logic        wr5;
  logic        wrw;
  logic [13:0] keep4;
  logic [4:0]  nv_sel_q;
  logic [4:0]  wdt_cfg_sel;

  cpd_cfg_if cfg ();

  always_comb
  begin
    img4_d   = img4_q;
    img5_d   = img5_q;
    act4_d   = act4_q;
    act5_d   = act5_q;
    wsw_d    = wsw_q;
    loaded_d = 1'b1;
    pin_en_d = pin_en_q;
    wr4      = reg_wr && (reg_addr == cpd_pkg::CFG4_ADDR);
    wr5      = reg_wr && (reg_addr == cpd_pkg::CFG5_ADDR);
    wrw      = reg_wr && (reg_addr == cpd_pkg::WDTC_ADDR);
    keep4    = '0;
    if (!loaded_q)
    begin
      // snapshot taken once after reset release, then frozen
      img4_d   = nv_cfg4 | ~cpd_pkg::CFG4_IMPL;
      img5_d   = nv_cfg5 | ~cpd_pkg::CFG5_IMPL;
      act4_d   = img4_d;
      act5_d   = img5_d;
      pin_en_d = reset_pin_enable;
    end
    else if (bulk_erase)
    begin
      // erase wins over a CFG4 or CFG5 write in the same cycle; a WDTC write still lands
      img4_d = cpd_pkg::CFG_ERASED;
      img5_d = cpd_pkg::CFG_ERASED;
    end
    else if (act4_q[cpd_pkg::CFG_WP_BIT])
    begin
      if (wr4)
      begin
        // sticky bits may only move toward protection
        img4_d = reg_wdata | ~cpd_pkg::CFG4_IMPL;
        img4_d = img4_d & (img4_q | ~cpd_pkg::CFG4_STICKY);
        if (lvp_session && img4_q[cpd_pkg::LVP_BIT])
          img4_d[cpd_pkg::LVP_BIT] = 1'b1;
        keep4 = {11'h000, {3{~img4_q[cpd_pkg::BB_EN_BIT]}}};
        img4_d[2:0] = (img4_q[2:0] & keep4[2:0])
                      | (img4_d[2:0] & ~keep4[2:0]);
      end
      if (wr5)
        img5_d = reg_wdata | ~cpd_pkg::CFG5_IMPL;
    end
    if (wrw && cfg.wdt_sw_ok)
      wsw_d = reg_wdata[cpd_pkg::WDT_SW_LSB +: 5];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      img4_q   <= cpd_pkg::CFG_ERASED;
      img5_q   <= cpd_pkg::CFG_ERASED;
      act4_q   <= cpd_pkg::CFG_ERASED;
      act5_q   <= cpd_pkg::CFG_ERASED;
      wsw_q    <= cpd_pkg::WDT_SW_RST;
      loaded_q <= 1'b0;
      pin_en_q <= 1'b1;
    end
    else if (clk_en)
    begin
      img4_q   <= img4_d;
      img5_q   <= img5_d;
      act4_q   <= act4_d;
      act5_q   <= act5_d;
      wsw_q    <= wsw_d;
      loaded_q <= loaded_d;
      pin_en_q <= pin_en_d;
    end
  end

  // ==========================================================================
  // snapshot fields and the software period onto the shared carrier
  assign cfg.low_voltage_prog_enable      = act4_q[cpd_pkg::LVP_BIT];
  assign cfg.saf_wp_n = act4_q[cpd_pkg::SAF_WP_BIT];
  assign cfg.ee_wp_n  = act4_q[cpd_pkg::EE_WP_BIT];
  assign cfg.cfg_wp_n = act4_q[cpd_pkg::CFG_WP_BIT];
  assign cfg.bb_wp_n  = act4_q[cpd_pkg::BB_WP_BIT];
  assign cfg.app_wp_n = act4_q[cpd_pkg::APP_WP_BIT];
  assign cfg.saf_en_n = act4_q[cpd_pkg::SAF_EN_BIT];
  assign cfg.bb_en_n  = act4_q[cpd_pkg::BB_EN_BIT];
  assign cfg.bb_size  = act4_q[cpd_pkg::BB_SZ_LSB +: 3];
  assign cfg.wdt_sel  = nv_sel_q;
  assign cfg.wdt_sw   = wsw_q;

  // selector is held from the snapshot, as the rest of the fields are
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      nv_sel_q <= cpd_pkg::WDT_SW_CTRL;
    else if (clk_en && !loaded_q)
      nv_sel_q <= wdt_cfg_sel;
  end

  // ==========================================================================
  // decoders
  logic in_boot;
  logic in_saf;
  logic addr_ok;
  logic region_allow;

  assign wdt_cfg_sel = nv_cfg5[13:9];

  cpd_wdt_period u_wdt (
    .cfg (cfg.wdt)
  );

  cpd_region_guard u_guard (
    .cfg     (cfg.guard),
    .addr    (prog_wr_addr),
    .in_boot (in_boot),
    .in_saf  (in_saf),
    .addr_ok (addr_ok),
    .allow   (region_allow)
  );

  // ==========================================================================
  // registered outputs and read data
  logic [13:0] rdata_d;
  logic [13:0] stat_w;

  always_comb
  begin
    stat_w  = {7'h00, cfg.wdt_sw_ok, in_boot, in_saf, addr_ok,
               ~cfg.low_voltage_prog_enable, cfg.bb_en_n, loaded_q};
    rdata_d = cpd_pkg::RD_ZERO;
    if (reg_rd)
    begin
      unique case (reg_addr)
        cpd_pkg::CFG4_ADDR: rdata_d = img4_q;
        cpd_pkg::CFG5_ADDR: rdata_d = img5_q;
        cpd_pkg::STAT_ADDR: rdata_d = stat_w;
        cpd_pkg::WDTC_ADDR: rdata_d = {9'h000, cfg.wdt_eff};
        default:            rdata_d = cpd_pkg::RD_ZERO;             // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata              <= cpd_pkg::RD_ZERO;
      cfg_valid              <= 1'b0;
      prog_wr_grant          <= 1'b0;
      eeprom_wr_grant        <= 1'b0;
      storage_area_flash_on  <= 1'b0;
      code_protect_on        <= 1'b0;
      pin_reset              <= 1'b0;
      hv_prog_required       <= 1'b0;
      watchdog_period_select <= cpd_pkg::WDT_SW_RST;
      wdt_ratio_exp          <= cpd_pkg::WDT_MIN_EXP;
      boot_block_words       <= 16'h0000;
      boot_block_last        <= 16'h0000;
    end
    else if (clk_en)
    begin
      reg_rdata              <= rdata_d;
      cfg_valid              <= loaded_q;
      prog_wr_grant          <= loaded_q && prog_wr_req && region_allow;
      eeprom_wr_grant        <= loaded_q && eeprom_wr_req && cfg.ee_wp_n;
      storage_area_flash_on  <= ~cfg.saf_en_n;
      code_protect_on        <= ~act5_q[cpd_pkg::CP_BIT];
      pin_reset              <= (cfg.low_voltage_prog_enable || pin_en_q) && !pin_lvl_q;
      hv_prog_required       <= ~cfg.low_voltage_prog_enable;
      watchdog_period_select <= cfg.wdt_eff;
      wdt_ratio_exp          <= cfg.wdt_exp;
      boot_block_words       <= cfg.bb_len;
      boot_block_last        <= (cfg.bb_len == 16'h0000) ? 16'h0000
                                : 16'(cfg.bb_len - 16'h0001);
    end
  end

endmodule : cpd_top
`default_nettype wire

//--- tb/cpd_top_sva.sv
// assertion checker bound to the configuration protection decoder
`timescale 1ns/1ps
`default_nettype none
module cpd_top_sva (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        reg_wr,
  input wire logic        prog_wr_req,
  input wire logic        eeprom_wr_req,
  input wire logic        external_reset_pin_n,
  input wire logic        cfg_valid,
  input wire logic        prog_wr_grant,
  input wire logic        eeprom_wr_grant,
  input wire logic        storage_area_flash_on,
  input wire logic        code_protect_on,
  input wire logic        pin_reset,
  input wire logic        hv_prog_required,
  input wire logic [4:0]  watchdog_period_select,
  input wire logic [4:0]  wdt_ratio_exp,
  input wire logic [15:0] boot_block_words,
  input wire logic [15:0] boot_block_last
);
  // single clock domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // watchdog period
  property p_wdt_exp;
    cfg_valid && $stable(watchdog_period_select) |-> wdt_ratio_exp ==
      ((watchdog_period_select > 5'h12) ? 5'h05 : watchdog_period_select + 5'h05);
  endproperty
  a_wdt_exp: assert property (p_wdt_exp)
    else $error("exponent does not follow period select");

  // three quiet cycles on the write strobe leave the period untouched
  property p_wdt_lock;
    $past(cfg_valid) && !$past(reg_wr) && !$past(reg_wr, 2) && !$past(reg_wr, 3)
      |-> $stable(watchdog_period_select);
  endproperty
  a_wdt_lock: assert property (p_wdt_lock)
    else $error("period select moved without a register write");

  // ==========================================================================
  // boot block geometry
  property p_bb_last;
    cfg_valid |-> boot_block_last ==
      ((boot_block_words == 16'h0000) ? 16'h0000 : boot_block_words - 16'h0001);
  endproperty
  a_bb_last: assert property (p_bb_last)
    else $error("boot block last address off its length");

  property p_bb_size;
    cfg_valid |-> boot_block_words inside {16'h0000, 16'h0200, 16'h0400, 16'h0800}
      && boot_block_words <= (cpd_pkg::PM_WORDS >> 1);
  endproperty
  a_bb_size: assert property (p_bb_size)
    else $error("boot block length not a legal size");

  // ==========================================================================
  // write grants answer a request of the cycle before
  property p_ee_grant;
    eeprom_wr_grant |-> $past(eeprom_wr_req);
  endproperty
  a_ee_grant: assert property (p_ee_grant)
    else $error("eeprom grant without request");

  property p_prog_grant;
    prog_wr_grant |-> $past(prog_wr_req);
  endproperty
  a_prog_grant: assert property (p_prog_grant)
    else $error("program grant without request");

  // ==========================================================================
  // snapshot held until the next reset
  property p_valid_hold;
    $rose(cfg_valid) |-> cfg_valid [*8];
  endproperty
  a_valid_hold: assert property (p_valid_hold)
    else $error("valid flag dropped without reset");

  property p_held;
    $past(cfg_valid) |-> $stable(boot_block_words) && $stable(boot_block_last)
      && $stable(code_protect_on) && $stable(storage_area_flash_on)
      && $stable(hv_prog_required);
  endproperty
  a_held: assert property (p_held)
    else $error("decoded output changed between resets");

  // ==========================================================================
  // shared reset pin; sync latency stays under six cycles
  property p_pin_lvp;
    (cfg_valid && !hv_prog_required && !external_reset_pin_n) [*6] |-> pin_reset;
  endproperty
  a_pin_lvp: assert property (p_pin_lvp)
    else $error("pin low under low-voltage mode gave no reset");

  property p_pin_idle;
    external_reset_pin_n [*6] |-> !pin_reset;
  endproperty
  a_pin_idle: assert property (p_pin_idle)
    else $error("pin reset while pin high");
endmodule : cpd_top_sva

bind cpd_top cpd_top_sva cpd_top_sva_i (
  .ref_clk, .reset_n, .reg_wr, .prog_wr_req, .eeprom_wr_req, .external_reset_pin_n,
  .cfg_valid, .prog_wr_grant, .eeprom_wr_grant, .storage_area_flash_on,
  .code_protect_on, .pin_reset, .hv_prog_required, .watchdog_period_select,
  .wdt_ratio_exp, .boot_block_words, .boot_block_last
);
`default_nettype wire

//--- tb/cpd_top_bench.sv
// self-checking bench for the configuration protection decoder
`timescale 1ns/1ps
`default_nettype none
module cpd_top_bench;
  logic        ref_clk, reset_n, clk_en, reg_wr, reg_rd;
  logic [15:0] reg_addr;
  logic [13:0] reg_wdata;
  logic [13:0] reg_rdata;
  logic [13:0] nv_cfg4;
  logic [13:0] nv_cfg5;
  logic        bulk_erase, lvp_session, reset_pin_enable, external_reset_pin_n;
  logic        prog_wr_req, eeprom_wr_req, cfg_valid, prog_wr_grant, eeprom_wr_grant;
  logic [15:0] prog_wr_addr;
  logic        storage_area_flash_on, code_protect_on, pin_reset, hv_prog_required;
  logic [4:0]  watchdog_period_select;
  logic [4:0]  wdt_ratio_exp;
  logic [15:0] boot_block_words;
  logic [15:0] boot_block_last;
  logic [15:0] w;
  logic [13:0] c;
  logic [4:0]  s;
  logic [4:0]  ws;
  logic [15:0] pa [4] = '{16'h01ff, 16'h0200, 16'h1f80, 16'h1f7f};
  int          fail_count;
  int          checked;
  int          k;
  int          j;

  cpd_top cpd_top_i (
    .ref_clk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .nv_cfg4, .nv_cfg5, .bulk_erase, .lvp_session, .reset_pin_enable,
    .external_reset_pin_n, .prog_wr_req, .prog_wr_addr, .eeprom_wr_req, .cfg_valid,
    .prog_wr_grant, .eeprom_wr_grant, .storage_area_flash_on, .code_protect_on,
    .pin_reset, .hv_prog_required, .watchdog_period_select, .wdt_ratio_exp,
    .boot_block_words, .boot_block_last
  );

  // 25 MHz reference clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // helpers
  task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask : check

  task automatic end_of_test;
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // new image through a reset; bounded wait for the snapshot
  task automatic do_reset(input logic [13:0] c4, input logic [13:0] c5, input int n);
    int i;
    reset_n <= 1'b0;
    nv_cfg4 <= c4;
    nv_cfg5 <= c5;
    repeat (n) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (i = 0; i < 20 && cfg_valid !== 1'b1; i++)
      @(posedge ref_clk);
    #1;
    if (cfg_valid !== 1'b1)
    begin
      fail_count++;
      end_of_test();
    end
  endtask : do_reset

  task automatic reg_write(input logic [15:0] a, input logic [13:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // read data stand only in the cycle after the strobe
  task automatic read_check(input logic [15:0] a, input logic [13:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check("read data", 16'(e), 16'(reg_rdata));
  endtask : read_check

  // one write request; the grant is registered at the taking edge
  task automatic wr_try(input logic ee, input logic [15:0] a, input logic e);
    @(posedge ref_clk);
    eeprom_wr_req <= ee;
    prog_wr_req   <= !ee;
    prog_wr_addr  <= a;
    @(posedge ref_clk);
    eeprom_wr_req <= 1'b0;
    prog_wr_req   <= 1'b0;
    #1;
    check("write grant", 16'(e), 16'(ee ? eeprom_wr_grant : prog_wr_grant));
  endtask : wr_try

  // ==========================================================================
  // main sequence
  initial
  begin
    {reset_n, reg_wr, reg_rd, bulk_erase, lvp_session, reset_pin_enable} = 6'h00;
    {prog_wr_req, eeprom_wr_req, reg_addr, reg_wdata, prog_wr_addr} = 48'h0;
    clk_en = 1'b1;
    external_reset_pin_n = 1'b1;
    nv_cfg4 = cpd_pkg::CFG_ERASED;
    nv_cfg5 = cpd_pkg::CFG_ERASED;
    fail_count = 0;
    checked = 0;
    // every selector code, boot size, enable and pin mode
    for (k = 0; k < 32; k++)
    begin
      s = 5'(k);
      reset_pin_enable <= s[0];
      do_reset({s[1], 8'hff, s}, {s, 8'hff, s[2]}, (k == 0) ? 16 : 3);
      ws = (k == 31) ? 5'h0b : s;
      w = s[3] ? 16'h0000 : (s[2:0] == 3'h7) ? 16'h0200 : (s[2:0] == 3'h6) ? 16'h0400 : 16'h0800;
      check("period select", 16'(ws), 16'(watchdog_period_select));
      check("exponent", 16'((ws > 5'h12) ? 5'h05 : ws + 5'h05), 16'(wdt_ratio_exp));
      check("boot words", w, boot_block_words);
      check("boot last", (w == 16'h0000) ? 16'h0000 : w - 16'h0001, boot_block_last);
      check("saf on", 16'(!s[4]), 16'(storage_area_flash_on));
      check("code protect", 16'(!s[2]), 16'(code_protect_on));
      check("hv required", 16'(!s[1]), 16'(hv_prog_required));
      external_reset_pin_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      #1;
      check("pin reset", 16'(s[1] | s[0]), 16'(pin_reset));
      external_reset_pin_n <= 1'b1;
    end
    // boot, storage, eeprom and config protections on then off, application the other way round; image writes under a programming session
    lvp_session <= 1'b1;
    for (k = 0; k < 2; k++)
    begin
      c = k ? 14'h2f0f : 14'h2087;
      do_reset(c, cpd_pkg::CFG_ERASED, 3);
      for (j = 0; j < 5; j++)
        wr_try(j == 4, pa[j % 4], (k ? 5'b10100 : 5'b01010) >> j);
      read_check(cpd_pkg::CFG4_ADDR, c | ~cpd_pkg::CFG4_IMPL);
      reg_write(cpd_pkg::CFG4_ADDR, 14'h0007);
      read_check(cpd_pkg::CFG4_ADDR, k ? 14'h3067 : 14'h30e7);
    end
    reg_write(cpd_pkg::CFG4_ADDR, 14'h3ff8);
    read_check(cpd_pkg::CFG4_ADDR, 14'h3067);
    lvp_session <= 1'b0;
    reg_write(cpd_pkg::CFG4_ADDR, 14'h0007);
    read_check(cpd_pkg::CFG4_ADDR, 14'h1067);
    check("boot words", 16'h0000, boot_block_words);
    check("saf on", 16'h0001, 16'(storage_area_flash_on));
    @(posedge ref_clk);
    bulk_erase <= 1'b1;
    @(posedge ref_clk);
    bulk_erase <= 1'b0;
    read_check(cpd_pkg::CFG4_ADDR, 14'h3fff);
    reg_write(cpd_pkg::CFG4_ADDR, 14'h3ffd);
    read_check(cpd_pkg::CFG4_ADDR, 14'h3ffd);
    reg_write(cpd_pkg::CFG4_ADDR, 14'h3fff);
    read_check(cpd_pkg::CFG4_ADDR, 14'h3fff);
    read_check(16'h8000, 14'h0000);
    // software period: open under all ones, locked otherwise
    for (k = 0; k < 2; k++)
    begin
      do_reset(cpd_pkg::CFG_ERASED, k ? 14'h25ff : 14'h3fff, 3);
      read_check(cpd_pkg::WDTC_ADDR, k ? 14'h0012 : 14'h000b);
      read_check(cpd_pkg::STAT_ADDR, k ? 14'h000b : 14'h004b);
      reg_write(cpd_pkg::CFG5_ADDR, 14'h0000);
      read_check(cpd_pkg::CFG5_ADDR, 14'h3ffe);
      reg_write(cpd_pkg::WDTC_ADDR, 14'h0003);
      ws = k ? 5'h12 : 5'h03;
      read_check(cpd_pkg::WDTC_ADDR, 14'(ws));
      check("period select", 16'(ws), 16'(watchdog_period_select));
      check("exponent", 16'(ws + 5'h05), 16'(wdt_ratio_exp));
      // a write while the clock enable is low must be lost
      @(posedge ref_clk);
      clk_en <= 1'b0;
      reg_write(cpd_pkg::WDTC_ADDR, 14'h0011);
      clk_en <= 1'b1;
      read_check(cpd_pkg::WDTC_ADDR, 14'(ws));
    end
    end_of_test();
  end
endmodule : cpd_top_bench
`default_nettype wire
